// File: hw/tec_core.sv
// Top of the 16-bit count-up timer/event counter with its three byte registers.
// Assumes one-cycle read/write strobes from the processor, at most one per cycle.
`timescale 1ns/1ps
`include "tec_defs.svh"
module tec_core
   import tec_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rd_low,
   input wire logic rd_high,
   input wire logic rd_ctrl,
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic wr_ctrl,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic timer_input_pin,
   input wire logic overflow_irq_enable,
   input wire logic power_down,
   output logic overflow_irq,
   output logic overflow_pulse
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] preload;
      logic [7:0] low_buf;
      logic [7:0] ctrl;
      tec_pw_t pw;
      logic [7:0] rdata;
      logic irq;
      logic ovf;
   } tec_st_t;
   tec_st_t st_ff;
   tec_st_t nxt_st;
   tec_acc_t acc;
   tec_pin_t pin_ev;
   logic tick;
   tec_mode_t mode;
   logic run;
   logic edge_sel;
   logic inc;
   logic inhibit;
   logic start_ev;
   logic stop_ev;
   logic [15:0] nxt_preload_w;

   assign acc = '{rd_low: rd_low, rd_high: rd_high, wr_low: wr_low, wr_high: wr_high,
                  wr_ctrl: wr_ctrl, rd_ctrl: rd_ctrl, wdata: wdata};

   tec_pin_sync u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_in(timer_input_pin),
      .pin_ev(pin_ev)
   );

   tec_prescaler u_pre (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Counting decisions
   assign mode = tec_mode_t'({st_ff.ctrl[`TEC_MODE_HI_BIT], st_ff.ctrl[`TEC_MODE_LO_BIT]});
   assign run = st_ff.ctrl[`TEC_RUN_BIT];
   assign edge_sel = st_ff.ctrl[`TEC_EDGE_BIT];
   assign inhibit = acc.rd_high | acc.rd_low | acc.wr_high;
   // Pulse start and end edges, chosen by edge select
   assign start_ev = edge_sel ? pin_ev.rise : pin_ev.fall;
   assign stop_ev = edge_sel ? pin_ev.fall : pin_ev.rise;

   always_comb
   begin
      inc = 1'b0;
      unique case (mode)
         TEC_MODE_TIMER: inc = run & tick;
         // Event edges are still counted in power down
         TEC_MODE_EVENT: inc = run & (edge_sel ? pin_ev.fall : pin_ev.rise);
         TEC_MODE_PULSE: inc = run & tick & (st_ff.pw == TEC_PW_COUNT) & ~stop_ev;
         TEC_MODE_OFF: inc = 1'b0;
      endcase
      if (inhibit)
         inc = 1'b0;
   end

   assign nxt_preload_w = {acc.wdata, st_ff.low_buf};

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.ovf = 1'b0;
      // Register writes
      if (acc.wr_low)
         nxt_st.low_buf = acc.wdata;
      if (acc.wr_high)
      begin
         nxt_st.preload = nxt_preload_w;
         if (!run)
            nxt_st.count = nxt_preload_w;
      end
      if (acc.rd_high)
         nxt_st.low_buf = st_ff.count[7:0];
      // Counting
      if (inc)
      begin
         if (st_ff.count == `TEC_COUNT_MAX)
         begin
            nxt_st.count = st_ff.preload;
            nxt_st.ovf = 1'b1;
         end
         else
            nxt_st.count = st_ff.count + 16'h0001;
      end
      // Pulse-width sequencing
      if (mode == TEC_MODE_PULSE && run)
      begin
         unique case (st_ff.pw)
            TEC_PW_IDLE: if (start_ev) nxt_st.pw = TEC_PW_COUNT;
            TEC_PW_COUNT:
               if (stop_ev)
               begin
                  nxt_st.pw = TEC_PW_DONE;
                  nxt_st.ctrl[`TEC_RUN_BIT] = 1'b0;
               end
            TEC_PW_DONE: nxt_st.pw = TEC_PW_IDLE;
            default: nxt_st.pw = TEC_PW_IDLE;
         endcase
      end
      else if (!run)
         nxt_st.pw = TEC_PW_IDLE;
      // Software control write wins over automatic stop
      if (acc.wr_ctrl)
         nxt_st.ctrl = acc.wdata;
      // Request flag; follows nxt_st.ovf for one cycle, gated by the enable, with no hold
      nxt_st.irq = nxt_st.ovf & overflow_irq_enable;
      // Read data
      nxt_st.rdata = 8'h00;
      if (acc.rd_low)
         nxt_st.rdata = st_ff.low_buf;
      else if (acc.rd_high)
         nxt_st.rdata = st_ff.count[15:8];
      else if (acc.rd_ctrl)
         nxt_st.rdata = st_ff.ctrl;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
         st_ff.ctrl <= `TEC_CTRL_RESET;
         st_ff.pw <= TEC_PW_IDLE;
      end
      else
         st_ff <= nxt_st;
   end

   assign rdata = st_ff.rdata;
   assign overflow_irq = st_ff.irq;
   assign overflow_pulse = st_ff.ovf;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_ovf_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (inc && st_ff.count == 16'hffff) |=> (st_ff.count == $past(st_ff.preload) && st_ff.ovf))
      else $error("overflow did not reload");
   chk_inc_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (inc && st_ff.count != 16'hffff && !wr_high) |=> st_ff.count == $past(st_ff.count) + 16'h1)
      else $error("count step wrong");
   chk_stop_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_high && !run) |=> st_ff.count == {$past(wdata), $past(st_ff.low_buf)})
      else $error("stopped preload not loaded");
   chk_run_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_high && run && !inc) |=> st_ff.count == $past(st_ff.count))
      else $error("running preload reached counter");
   chk_high_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_high |=> st_ff.low_buf == $past(st_ff.count[7:0]))
      else $error("low byte not latched");
   chk_no_count_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !run |-> !inc)
      else $error("counted while stopped");
   chk_inhibit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rd_low || rd_high || wr_high) |-> !inc)
      else $error("counted during access");
   chk_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      overflow_irq |-> (st_ff.ovf && $past(overflow_irq_enable)))
      else $error("interrupt not gated");
   chk_auto_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (run && mode != TEC_MODE_PULSE && !wr_ctrl) |=> run)
      else $error("run bit cleared by hardware");
   chk_pulse_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_PULSE && run && st_ff.pw == TEC_PW_COUNT && stop_ev && !wr_ctrl)
      |=> !run ##1 !inc)
      else $error("pulse end not stopped");

   ////////////////////////////////////////////////////////////////////////////
   // Clock source and event checks
   chk_pd_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_EVENT && run && power_down && !inhibit && st_ff.count != 16'hffff
      && (edge_sel ? pin_ev.fall : pin_ev.rise)) |=> st_ff.count == $past(st_ff.count) + 16'h1)
      else $error("event lost in power down");

   chk_event_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_EVENT && run && !edge_sel && pin_ev.rise && !inhibit)
      |-> inc)
      else $error("rising event not counted");

   chk_event_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_EVENT && run && edge_sel && pin_ev.fall && !inhibit)
      |-> inc)
      else $error("falling event not counted");

   chk_event_edge_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_EVENT && !(edge_sel ? pin_ev.fall : pin_ev.rise))
      |-> !inc)
      else $error("counted on the wrong edge");

   chk_timer_tick: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_TIMER && run && tick && !inhibit)
      |-> inc)
      else $error("timer tick not counted");

   chk_timer_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_TIMER && !tick)
      |-> !inc)
      else $error("timer counted between ticks");

   chk_pulse_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_PULSE && !tick)
      |-> !inc)
      else $error("pulse counted between ticks");

   chk_mode_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_OFF)
      |-> !inc)
      else $error("counted with no mode");

   // Register access, overflow and interrupt checks
   chk_low_buffer: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_low
      |=> (st_ff.low_buf == $past(wdata) && st_ff.preload == $past(st_ff.preload)))
      else $error("low write not buffered");

   chk_high_commit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_high
      |=> st_ff.preload == {$past(wdata), $past(st_ff.low_buf)})
      else $error("high write not committed");

   chk_low_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_low
      |=> rdata == $past(st_ff.low_buf))
      else $error("low read not from buffer");

   chk_high_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_high
      |=> rdata == $past(st_ff.count[15:8]))
      else $error("high read wrong");

   chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(rd_low || rd_high || rd_ctrl)
      |=> rdata == 8'h00)
      else $error("read data not idle");

   chk_irq_raise: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (inc && st_ff.count == 16'hffff && overflow_irq_enable)
      |=> overflow_irq)
      else $error("enabled interrupt missing");

   chk_ovf_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
      overflow_pulse
      |-> ($past(inc) && $past(st_ff.count) == 16'hffff))
      else $error("overflow without full count");

   chk_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_ctrl
      |=> st_ff.ctrl == $past(wdata))
      else $error("control write lost");

   chk_ctrl_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_ctrl
      |=> rdata == $past(st_ff.ctrl))
      else $error("control read wrong");

   chk_read_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rd_low || rd_high)
      |=> st_ff.count == $past(st_ff.count))
      else $error("count moved during read");

   // Pulse-width checks
   chk_pulse_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_PULSE && run && st_ff.pw == TEC_PW_IDLE && start_ev)
      |=> st_ff.pw == TEC_PW_COUNT)
      else $error("pulse start missed");

   chk_pulse_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_PULSE && st_ff.pw != TEC_PW_COUNT)
      |-> !inc)
      else $error("pulse counted outside window");

   chk_pulse_rearm: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !run
      |=> st_ff.pw == TEC_PW_IDLE)
      else $error("pulse not rearmed");

   chk_pulse_stop_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode == TEC_MODE_PULSE && run && edge_sel && st_ff.pw == TEC_PW_COUNT && pin_ev.fall
      && !wr_ctrl) |=> !run)
      else $error("high pulse end not stopped");
endmodule : tec_core

// File: hw/tec_defs.svh
// Constants for the 16-bit timer/event counter: field positions, encodings, timing.
// Assumes a 100 MHz ref_clk and a byte-wide data-memory access port.
`ifndef TEC_DEFS_SVH
`define TEC_DEFS_SVH
`define TEC_RUN_BIT 4
`define TEC_EDGE_BIT 3
`define TEC_MODE_HI_BIT 7
`define TEC_MODE_LO_BIT 6
`define TEC_CTRL_RESET 8'h00
`define TEC_CLK_PERIOD_NS 10
`define TEC_PRESCALE 4
`define TEC_COUNT_MAX 16'hffff
`endif

// File: hw/tec_pkg.sv
// Types shared by the timer/event counter files.
// Assumes tec_defs.svh is included by the users of the constants.
package tec_pkg;
   typedef enum logic [1:0] {
      TEC_MODE_OFF = 2'b00,
      TEC_MODE_EVENT = 2'b01,
      TEC_MODE_TIMER = 2'b10,
      TEC_MODE_PULSE = 2'b11
   } tec_mode_t;
   typedef enum logic [1:0] {
      TEC_PW_IDLE = 2'b00,
      TEC_PW_COUNT = 2'b01,
      TEC_PW_DONE = 2'b10
   } tec_pw_t;
   typedef struct packed {
      logic rd_low;
      logic rd_high;
      logic wr_low;
      logic wr_high;
      logic wr_ctrl;
      logic rd_ctrl;
      logic [7:0] wdata;
   } tec_acc_t;
   typedef struct packed {
      logic rise;
      logic fall;
      logic level;
   } tec_pin_t;
endpackage : tec_pkg

// File: hw/tec_pin_sync.sv
// Two-stage synchroniser and edge detector for the timer input pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
module tec_pin_sync
   import tec_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output tec_pin_t pin_ev
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } tec_sync_st_t;
   tec_sync_st_t st_ff;
   tec_sync_st_t nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.s1 = pin_in;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
   // Edges compare stage two with stage three only
   assign pin_ev.rise = st_ff.s2 & ~st_ff.s3;
   assign pin_ev.fall = ~st_ff.s2 & st_ff.s3;
   assign pin_ev.level = st_ff.s2;
endmodule : tec_pin_sync

// File: hw/tec_prescaler.sv
// Divide-by-4 prescaler giving a one-cycle tick at the falling edge of the timer clock.
// Assumes a free-running ref_clk.
`timescale 1ns/1ps
`include "tec_defs.svh"
module tec_prescaler
   import tec_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   output logic tick
);
   typedef struct packed {
      logic [1:0] cnt;
   } tec_pre_st_t;
   tec_pre_st_t st_ff;
   tec_pre_st_t nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.cnt = st_ff.cnt + 2'h1;
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
   // Timer clock is high for counts 2..3, its falling edge is at count 3 -> 0
   assign tick = (st_ff.cnt == 2'(`TEC_PRESCALE - 1));
endmodule : tec_prescaler

// File: test/tec_pin_source.sv
// Far-side model: a source of edges and pulses on the timer input pin.
// Assumes the bench calls its tasks and shares ref_clk with the design.
`timescale 1ns/1ps
module tec_pin_source
(
   input wire logic ref_clk,
   output logic pin_out
);
   // The pin is always driven, as when the port direction makes it an input
   initial pin_out = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic set_level(input logic lvl);
      @(posedge ref_clk);
      pin_out <= lvl;
      repeat (8) @(posedge ref_clk);
   endtask : set_level
   // Edges are spaced well beyond the synchroniser depth
   task automatic toggle(input int n);
      repeat (n)
      begin
         repeat (8) @(posedge ref_clk);
         pin_out <= ~pin_out;
      end
      repeat (8) @(posedge ref_clk);
   endtask : toggle
   task automatic pulse(input int len);
      @(posedge ref_clk);
      pin_out <= ~pin_out;
      repeat (len) @(posedge ref_clk);
      pin_out <= ~pin_out;
      repeat (8) @(posedge ref_clk);
   endtask : pulse
endmodule : tec_pin_source

// File: test/tb_timer_event_counter_16bit.sv
// Self-checking bench for the 16-bit timer/event counter top, tec_core.
// Assumes the pin source model in tec_pin_source.sv and the design under hw/.
`timescale 1ns/1ps
module tb_timer_event_counter_16bit;
   import tec_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd_low = 1'b0;
   logic rd_high = 1'b0;
   logic rd_ctrl = 1'b0;
   logic [2:0] wr_s = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic pin;
   logic irq_en = 1'b0;
   logic pd = 1'b0;
   logic irq;
   logic ovf;
   int mismatches = 0;
   int samples_checked = 0;
   int n_ovf = 0;
   int n_irq = 0;
   int cycles = 0;
   logic [15:0] v;
   logic [15:0] w;
   logic [7:0] c;
   // Rows: control byte, pin toggles from low, power down, expected count
   logic [31:0] rows [5] = '{32'h50_05_01_03, 32'h58_05_00_02, 32'h50_05_00_03,
      32'h40_05_00_00, 32'h10_05_00_00};
   initial forever #5 ref_clk = ~ref_clk;
   tec_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .rd_low(rd_low), .rd_high(rd_high),
      .rd_ctrl(rd_ctrl), .wr_low(wr_s[0]), .wr_high(wr_s[1]), .wr_ctrl(wr_s[2]),
      .wdata(wdata), .rdata(rdata), .timer_input_pin(pin), .overflow_irq_enable(irq_en),
      .power_down(pd), .overflow_irq(irq), .overflow_pulse(ovf));
   tec_pin_source src (.ref_clk(ref_clk), .pin_out(pin));
   always @(posedge ref_clk)
   begin
      n_ovf <= n_ovf + int'(ovf === 1'b1);
      n_irq <= n_irq + int'(irq === 1'b1);
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         mismatches++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input int sel, input logic [7:0] d);
      @(posedge ref_clk);
      wr_s[sel] <= 1'b1;
      wdata <= d;
      @(posedge ref_clk);
      wr_s <= 3'h0;
   endtask : wr
   task automatic rd16(output logic [15:0] r);
      @(posedge ref_clk);
      rd_high <= 1'b1;
      @(posedge ref_clk);
      rd_high <= 1'b0;
      rd_low <= 1'b1;
      #1 r[15:8] = rdata;
      @(posedge ref_clk);
      rd_low <= 1'b0;
      #1 r[7:0] = rdata;
   endtask : rd16
   task automatic rdc(output logic [7:0] r);
      @(posedge ref_clk);
      rd_ctrl <= 1'b1;
      @(posedge ref_clk);
      rd_ctrl <= 1'b0;
      #1 r = rdata;
   endtask : rdc
   task automatic load(input logic [15:0] p);
      wr(0, p[7:0]);
      wr(1, p[15:8]);
   endtask : load
   // Mode bits settle before the run bit is set
   task automatic ctl(input logic [7:0] d);
      wr(2, d & 8'hef);
      wr(2, d);
   endtask : ctl
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdc(c);
      check({8'h00, c}, 16'h0000);
      foreach (rows[i])
      begin
         wr(2, 8'h00);
         src.set_level(1'b0);
         load(16'h0000);
         pd <= rows[i][8];
         ctl(rows[i][31:24]);
         rdc(c);
         check({8'h00, c}, {8'h00, rows[i][31:24]});
         src.toggle(rows[i][23:16]);
         rd16(v);
         check(v, {8'h00, rows[i][7:0]});
         pd <= 1'b0;
      end
      // Running preload write waits for overflow; irq follows the enable
      for (int en = 1; en >= 0; en--)
      begin
         wr(2, 8'h00);
         src.set_level(1'b0);
         irq_en <= en[0];
         load(16'hfffe);
         ctl(8'h50);
         load(16'h0010);
         rd16(v);
         check(v, 16'hfffe);
         src.toggle(3);
         rd16(v);
         check(v, 16'h0010);
      end
      check(16'(n_ovf), 16'h0002);
      check(16'(n_irq), 16'h0001);
      // Timer mode: one count per four clocks, run bit left alone
      wr(2, 8'h00);
      load(16'h0000);
      ctl(8'h90);
      repeat (400) @(posedge ref_clk);
      rdc(c);
      check({8'h00, c}, 16'h0090);
      wr(2, 8'h80);
      rd16(v);
      check({15'h0, v >= 16'd99 && v <= 16'd102}, 16'h0001);
      // Single-shot pulse width, both edge selects
      for (int te = 0; te < 2; te++)
      begin
         wr(2, 8'h00);
         src.set_level(te == 0);
         load(16'h0000);
         ctl(te ? 8'hd8 : 8'hd0);
         src.set_level(te == 0);
         src.pulse(40);
         rdc(c);
         check({8'h00, c}, te ? 16'h00c8 : 16'h00c0);
         rd16(v);
         check({15'h0, v >= 16'd9 && v <= 16'd11}, 16'h0001);
         src.pulse(40);
         rd16(w);
         check(w, v);
      end
      // A pin already at its active level starts no measurement
      wr(2, 8'h00);
      src.set_level(1'b0);
      load(16'h0000);
      ctl(8'hd0);
      repeat (40) @(posedge ref_clk);
      rd16(v);
      check(v, 16'h0000);
      // Reset in mid-run clears control and count
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdc(c);
      check({8'h00, c}, 16'h0000);
      rd16(v);
      check(v, 16'h0000);
      test_done();
   end
endmodule : tb_timer_event_counter_16bit
